// ### bench/asrs_far_model.sv
// Far-side model: converter sample tick and frequency generator observer
`timescale 1ns/100ps
`default_nettype none
module asrs_far_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Tick enable from the bench and reference strobe from the scaler
  input wire logic tick_en,
  input wire logic freq_ref_strobe,
  // Tick out and counts seen
  output logic sample_tick,
  output logic [15:0] tick_count,
  output logic [15:0] strobe_count
);
  logic [1:0] div;
  // fixed tick period
  // Four cycles apart keeps the three-cycle minimum with margin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 2'h0;
      sample_tick <= 1'b0;
      tick_count <= 16'h0000;
      strobe_count <= 16'h0000;
    end else begin
      div <= div + 2'h1;
      sample_tick <= tick_en && (div == 2'h3);
      if (sample_tick) begin
        tick_count <= tick_count + 16'h0001;
      end
      if (freq_ref_strobe) begin
        strobe_count <= strobe_count + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/asrs_top_sva.sv
// Checker on the scaler top-level ports
`timescale 1ns/100ps
`default_nettype none
module asrs_top_sva (
  // Clock, reset and bus handshake
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Tick input and reference outputs
  input wire logic sample_tick,
  input wire logic freq_ref_strobe,
  input wire logic [15:0] freq_ref,
  input wire logic [15:0] base_freq_active,
  input wire logic [15:0] max_freq_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready missing after setup");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("pready outside access");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_stb; freq_ref_strobe |-> $past(sample_tick, 2); endproperty
  a_stb: assert property (p_stb) else $error("strobe not two cycles after tick");
  property p_chg; $changed(freq_ref) |-> freq_ref_strobe; endproperty
  a_chg: assert property (p_chg) else $error("reference moved without strobe");
  property p_gap; freq_ref_strobe |=> !freq_ref_strobe [*2]; endproperty
  a_gap: assert property (p_gap) else $error("strobes too close");
  property p_base; base_freq_active >= asrs_pkg::FREQ_BASE_MIN && base_freq_active <= max_freq_active; endproperty
  a_base: assert property (p_base) else $error("base limit out of range");
  property p_max; max_freq_active <= asrs_pkg::FREQ_LIMIT; endproperty
  a_max: assert property (p_max) else $error("max limit above ceiling");
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking testbench for the speed reference scaler
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, tick, stb, err;
  logic sel_t = 1'b0;
  logic tick_en = 1'b0;
  logic [11:0] vs = 12'h000, cs = 12'h000, ps = 12'h000;
  logic [15:0] fref, base_a, max_a, tcnt, scnt, s;
  int fail_count = 0;
  int compares = 0;
  // Clock at 50 ns period
  always #25 pclk = ~pclk;
  asrs_top asrs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .volt_sample(vs),
    .curr_sample(cs), .operator_pot_channel(ps), .sample_tick(tick), .channel_select_terminal(sel_t),
    .freq_ref(fref), .freq_ref_strobe(stb), .base_freq_active(base_a), .max_freq_active(max_a));
  asrs_far_model asrs_far_model_inst (.pclk(pclk), .presetn(presetn), .tick_en(tick_en),
    .freq_ref_strobe(stb), .sample_tick(tick), .tick_count(tcnt), .strobe_count(scnt));
  task summarize;
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 16, 1'b1);
    if (n >= 16) summarize;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Waits for k ticks, then until the reference of the last one has landed
  task go(input int k);
    int n, t;
    n = 0;
    @(posedge pclk);
    t = tcnt + k;
    while (tcnt < t && n < 8 * k + 8) begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    chk(n < 8 * k + 8, 1'b1);
    if (n >= 8 * k + 8) summarize;
  endtask
  function automatic logic [31:0] cfg(input logic [4:0] f, input logic [1:0] p, input logic as, ve, ce);
    return {21'h0, ce, ve, f, as, p, 1'b0};
  endfunction
  task t_reset;
    rdc(8'h00, 32'h1388);
    rdc(8'h08, 32'h1388);
    rdc(8'h04, 32'h1388);
    rdc(8'h0C, 32'h1388);
    rdc(8'h10, 32'h680);
    rdc(8'h1C, 32'h6400);
    rdc(8'h24, 32'h0);
    rdc(8'h28, 32'h6400);
    apb(1'b0, 8'h3C, 32'h0);
    chk(err, 1'b1);
  endtask
  // Limits clamp against each other and the fixed bounds
  task t_limits;
    wr(8'h00, 32'h0);
    rdc(8'h00, 32'h0BB8);
    wr(8'h04, 32'hFFFF);
    rdc(8'h04, 32'h9C40);
    wr(8'h00, 32'hFFFF);
    rdc(8'h00, 32'h9C40);
    wr(8'h04, 32'h0);
    rdc(8'h04, 32'h9C40);
    wr(8'h00, 32'h0BB8);
    wr(8'h04, 32'h1388);
    wr(8'h00, 32'h1388);
    wr(8'h08, 32'h0FA0);
    wr(8'h0C, 32'h1770);
    wr(8'h10, 32'h681);
    repeat (2) @(posedge pclk);
    chk(base_a, 16'h0FA0);
    chk(max_a, 16'h1770);
    wr(8'h10, 32'h680);
    repeat (2) @(posedge pclk);
    chk(base_a, 16'h1388);
    chk(max_a, 16'h1388);
  endtask
  task t_pair;
    logic [1:0] pc [3] = '{2'h0, 2'h2, 2'h3};
    logic [15:0] ex [6] = '{16'h03E8, 16'h07D0, 16'h03E8, 16'h0000, 16'h07D0, 16'h0000};
    wr(8'h14, 32'h03E8);
    wr(8'h18, 32'h03E8);
    wr(8'h20, 32'h07D0);
    wr(8'h24, 32'h07D0);
    for (int i = 0; i < 6; i++) begin
      sel_t <= i[0];
      wr(8'h10, cfg(5'h01, pc[i / 2], 1'b1, 1'b1, 1'b1));
      go(3);
      chk(fref, ex[i]);
    end
    wr(8'h10, cfg(5'h01, 2'h0, 1'b0, 1'b1, 1'b1));
    go(3);
    chk(fref, 32'h0BB8);
  endtask
  task t_map;
    logic [7:0] b;
    logic [31:0] pt [5] = '{32'h6400, 32'h6400, 32'h3214, 32'h3214, 32'h3214};
    logic en [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [11:0] sv [5] = '{12'h000, 12'hFFF, 12'h000, 12'h000, 12'hC00};
    logic [15:0] ex [5] = '{16'h03E8, 16'h1388, 16'h0000, 16'h03E8, 16'h1388};
    for (int c = 0; c < 2; c++) begin
      b = c[0] ? 8'h20 : 8'h14;
      sel_t <= c[0];
      wr(b, 32'h03E8);
      wr(b + 8'h04, 32'h1388);
      for (int i = 0; i < 5; i++) begin
        wr(b + 8'h08, pt[i]);
        wr(8'h10, cfg(5'h01, 2'h0, 1'b1, en[i] | c[0], en[i] | !c[0]));
        vs <= sv[i];
        cs <= sv[i];
        go(3);
        chk(fref, ex[i]);
      end
    end
  endtask
  task t_avg;
    int n [3] = '{1, 3, 30};
    sel_t <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      ps <= 12'h000;
      wr(8'h10, cfg(n[j][4:0], 2'h2, 1'b1, 1'b1, 1'b1));
      go(n[j] + 1);
      ps <= 12'hFFF;
      for (int k = 1; k <= n[j]; k++) begin
        go(1);
        chk(fref, 5000 * k / n[j]);
      end
    end
  endtask
  // Deadband: follows while settling, then holds inside the band
  task t_dead;
    ps <= 12'h000;
    wr(8'h10, cfg(5'h1F, 2'h2, 1'b1, 1'b1, 1'b1));
    go(20);
    ps <= 12'hFFF;
    go(1);
    chk(fref, 32'h0138);
    ps <= 12'h000;
    go(18);
    go(asrs_pkg::SETTLE_TICKS);
    s = scnt;
    // Pot code 8 maps to 0.09 Hz, just inside the band; code 9 to 0.10 Hz, on its edge
    ps <= 12'h008;
    go(20);
    chk(scnt, s);
    chk(fref, 32'h0);
    ps <= 12'h009;
    go(20);
    chk(fref, 32'h000A);
    ps <= 12'hFFF;
    go(1);
    chk(fref, 32'h0141);
    go(1);
    chk(fref, 32'h0279);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    tick_en <= 1'b1;
    t_reset;
    t_limits;
    t_pair;
    t_map;
    t_avg;
    t_dead;
    summarize;
  end
endmodule
bind asrs_top asrs_top_sva asrs_top_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick), .freq_ref_strobe(freq_ref_strobe),
  .freq_ref(freq_ref), .base_freq_active(base_freq_active), .max_freq_active(max_freq_active));
`default_nettype wire

// ### inc/asrs_pkg.sv
// Package: register map, field layout, reset values and timing for the speed reference scaler
package asrs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_BASE1 = 8'h00;
  localparam logic [7:0] OFS_MAX1 = 8'h04;
  localparam logic [7:0] OFS_BASE2 = 8'h08;
  localparam logic [7:0] OFS_MAX2 = 8'h0C;
  localparam logic [7:0] OFS_CFG = 8'h10;
  localparam logic [7:0] OFS_VSF = 8'h14;
  localparam logic [7:0] OFS_VEF = 8'h18;
  localparam logic [7:0] OFS_VPT = 8'h1C;
  localparam logic [7:0] OFS_CSF = 8'h20;
  localparam logic [7:0] OFS_CEF = 8'h24;
  localparam logic [7:0] OFS_CPT = 8'h28;
  localparam logic [7:0] OFS_REF = 8'h2C;
  localparam logic [7:0] OFS_RAW = 8'h30;
  localparam logic [7:0] OFS_STAT = 8'h34;

  // Configuration register fields
  localparam int CFG_MOTOR2 = 0;
  localparam int CFG_PAIR_LO = 1;
  localparam int CFG_PAIR_HI = 2;
  localparam int CFG_SEL_ASSIGNED = 3;
  localparam int CFG_FILT_LO = 4;
  localparam int CFG_FILT_HI = 8;
  localparam int CFG_VSTART_EN = 9;
  localparam int CFG_CSTART_EN = 10;
  localparam int CFG_WIDTH = 11;
  // Point registers: start in low byte, end in second byte
  localparam int PT_START_LO = 0;
  localparam int PT_START_HI = 6;
  localparam int PT_END_LO = 8;
  localparam int PT_END_HI = 14;

  // Frequencies are in units of 0.01 Hz
  localparam logic [15:0] FREQ_BASE_MIN = 16'h0BB8;
  localparam logic [15:0] FREQ_LIMIT = 16'h9C40;
  localparam logic [15:0] FREQ_BASE_RST = 16'h1388;
  localparam logic [15:0] FREQ_MAX_RST = 16'h1388;
  localparam logic [15:0] FREQ_MAP_RST = 16'h0000;
  localparam logic [6:0] POINT_START_RST = 7'h00;
  localparam logic [6:0] POINT_END_RST = 7'h64;
  localparam logic [6:0] POINT_FULL = 7'h64;
  localparam logic [1:0] PAIR_RST = 2'h0;
  localparam logic START_EN_RST = 1'b1;
  localparam logic [4:0] FILT_RST = 5'h08;
  localparam logic [4:0] FILT_DEADBAND = 5'h1F;
  localparam logic [4:0] FILT_MAX_AVG = 5'h1E;
  localparam logic [4:0] DEADBAND_AVG = 5'h10;
  localparam logic [15:0] DEADBAND_WIDTH = 16'h000A;

  // Input-pair select codes
  localparam logic [1:0] PAIR_VOLT_CURR = 2'h0;
  localparam logic [1:0] PAIR_POT_VOLT = 2'h2;
  localparam logic [1:0] PAIR_POT_CURR = 2'h3;

  // Analog sample full scale
  localparam int SAMPLE_W = 12;
  localparam logic [11:0] SAMPLE_FULL = 12'hFFF;

  // Timing: sample tick period and deadband settle time
  localparam int CLK_HZ = 20000000;
  localparam int TICK_MS = 2;
  localparam int SETTLE_MS = 500;
  localparam int SETTLE_TICKS = SETTLE_MS / TICK_MS;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
endpackage

// ### rtl/asrs_chan_map.sv
// Linear start/end point mapping of one analog channel onto a frequency
`timescale 1ns/100ps
`default_nettype none
module asrs_chan_map (
  // Channel sample, 0 to full scale
  input wire logic [11:0] sample,
  // Mapping settings
  input wire logic [15:0] start_freq,
  input wire logic [15:0] end_freq,
  input wire logic [6:0] start_point,
  input wire logic [6:0] end_point,
  input wire logic start_zero,
  // Mapped frequency, 0.01 Hz units
  output logic [15:0] freq
);
  // Percent of range to sample units
  function automatic logic [11:0] scale_point(input logic [6:0] pct);
    logic [18:0] prod;
    prod = 19'(pct) * 19'(asrs_pkg::SAMPLE_FULL);
    return 12'(prod / 19'(asrs_pkg::POINT_FULL));
  endfunction

  logic [11:0] xs;
  logic [11:0] xe;
  logic signed [17:0] delta;
  logic signed [30:0] prod;
  logic signed [30:0] quot;
  logic signed [17:0] line;

  assign xs = scale_point(start_point);
  assign xe = scale_point(end_point);

  // Interpolation on the major segment; only meaningful when xs <= sample < xe
  always_comb begin
    delta = $signed({2'b00, end_freq}) - $signed({2'b00, start_freq});
    prod = 31'(delta) * $signed({19'h00000, sample - xs});
    quot = (xe > xs) ? prod / $signed({19'h00000, xe - xs}) : 31'sh00000000;
    line = $signed({2'b00, start_freq}) + 18'(quot);
  end

  // Below start, above end and in-range selection
  always_comb begin
    if (sample < xs) begin
      freq = start_zero ? 16'h0000 : start_freq;
    end else if (sample >= xe) begin
      freq = end_freq;
    end else begin
      freq = line[15:0];
    end
  end
endmodule
`default_nettype wire

// ### rtl/asrs_top.sv
// Analog speed reference scaler: APB registers, channel select, averaging and deadband
`timescale 1ns/100ps
`default_nettype none
module asrs_top #(
  parameter int AVG_DEPTH = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog samples from the converter, same clock
  input wire logic [11:0] volt_sample,
  input wire logic [11:0] curr_sample,
  input wire logic [11:0] operator_pot_channel,
  // Sample tick from the drive controller, one cycle per 2 ms
  input wire logic sample_tick,
  // Select terminal pin, asynchronous
  input wire logic channel_select_terminal,
  // Frequency reference to the motor frequency generator
  output logic [15:0] freq_ref,
  output logic freq_ref_strobe,
  output logic [15:0] base_freq_active,
  output logic [15:0] max_freq_active
);
  localparam int PW = $clog2(AVG_DEPTH);

  // The ring pointer wraps at a power of two and must cover the longest window
  if (AVG_DEPTH < 32 || AVG_DEPTH != (1 << PW)) begin : g_depth_check
    $error("AVG_DEPTH must be a power of two of at least 32");
  end

  // Clamp a value into a closed range
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // Settings
  logic [15:0] base_freq_setting;
  logic [15:0] max_freq_setting;
  logic [15:0] base_freq_setting_motor2;
  logic [15:0] max_freq_setting_motor2;
  logic [10:0] cfg;
  logic [15:0] volt_chan_start_freq;
  logic [15:0] volt_chan_end_freq;
  logic [6:0] volt_chan_start_point;
  logic [6:0] volt_chan_end_point;
  logic [15:0] curr_chan_start_freq;
  logic [15:0] curr_chan_end_freq;
  logic [6:0] curr_chan_start_point;
  logic [6:0] curr_chan_end_point;

  logic motor2_sel;
  logic [1:0] input_pair_select_code;
  logic select_assigned;
  logic [4:0] reference_filter_setting;
  logic volt_chan_start_enable;
  logic curr_chan_start_enable;

  assign motor2_sel = cfg[asrs_pkg::CFG_MOTOR2];
  assign input_pair_select_code = cfg[asrs_pkg::CFG_PAIR_HI:asrs_pkg::CFG_PAIR_LO];
  assign select_assigned = cfg[asrs_pkg::CFG_SEL_ASSIGNED];
  assign reference_filter_setting = cfg[asrs_pkg::CFG_FILT_HI:asrs_pkg::CFG_FILT_LO];
  assign volt_chan_start_enable = cfg[asrs_pkg::CFG_VSTART_EN];
  assign curr_chan_start_enable = cfg[asrs_pkg::CFG_CSTART_EN];

  // APB decode; every access completes with no wait states
  logic wr_en;
  logic [15:0] wd16;
  assign wr_en = psel & penable & pwrite & pready;
  assign wd16 = pwdata[15:0];

  // base frequency writes clamp between 30 Hz and the own maximum
  // maximum writes clamp between the own base and 400 Hz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_freq_setting <= asrs_pkg::FREQ_BASE_RST;
      max_freq_setting <= asrs_pkg::FREQ_MAX_RST;
      base_freq_setting_motor2 <= asrs_pkg::FREQ_BASE_RST;
      max_freq_setting_motor2 <= asrs_pkg::FREQ_MAX_RST;
    end else if (wr_en) begin
      case (paddr)
        asrs_pkg::OFS_BASE1: base_freq_setting <= clamp16(wd16, asrs_pkg::FREQ_BASE_MIN, max_freq_setting);
        asrs_pkg::OFS_MAX1: max_freq_setting <= clamp16(wd16, base_freq_setting, asrs_pkg::FREQ_LIMIT);
        asrs_pkg::OFS_BASE2: base_freq_setting_motor2 <= clamp16(wd16, asrs_pkg::FREQ_BASE_MIN,
                                                                 max_freq_setting_motor2);
        asrs_pkg::OFS_MAX2: max_freq_setting_motor2 <= clamp16(wd16, base_freq_setting_motor2,
                                                               asrs_pkg::FREQ_LIMIT);
        default: ;
      endcase
    end
  end

  // Configuration and channel mapping settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= {asrs_pkg::START_EN_RST, asrs_pkg::START_EN_RST, asrs_pkg::FILT_RST, 1'b0, asrs_pkg::PAIR_RST, 1'b0};
      volt_chan_start_freq <= asrs_pkg::FREQ_MAP_RST;
      volt_chan_end_freq <= asrs_pkg::FREQ_MAP_RST;
      volt_chan_start_point <= asrs_pkg::POINT_START_RST;
      volt_chan_end_point <= asrs_pkg::POINT_END_RST;
      curr_chan_start_freq <= asrs_pkg::FREQ_MAP_RST;
      curr_chan_end_freq <= asrs_pkg::FREQ_MAP_RST;
      curr_chan_start_point <= asrs_pkg::POINT_START_RST;
      curr_chan_end_point <= asrs_pkg::POINT_END_RST;
    end else if (wr_en) begin
      case (paddr)
        asrs_pkg::OFS_CFG: begin
          // A filter code of zero is out of range and is taken as one
          cfg <= pwdata[asrs_pkg::CFG_WIDTH-1:0];
          if (pwdata[asrs_pkg::CFG_FILT_HI:asrs_pkg::CFG_FILT_LO] == 5'h00) begin
            cfg[asrs_pkg::CFG_FILT_HI:asrs_pkg::CFG_FILT_LO] <= 5'h01;
          end
        end
        asrs_pkg::OFS_VSF: volt_chan_start_freq <= clamp16(wd16, 16'h0000, asrs_pkg::FREQ_LIMIT);
        asrs_pkg::OFS_VEF: volt_chan_end_freq <= clamp16(wd16, 16'h0000, asrs_pkg::FREQ_LIMIT);
        asrs_pkg::OFS_CSF: curr_chan_start_freq <= clamp16(wd16, 16'h0000, asrs_pkg::FREQ_LIMIT);
        asrs_pkg::OFS_CEF: curr_chan_end_freq <= clamp16(wd16, 16'h0000, asrs_pkg::FREQ_LIMIT);
        asrs_pkg::OFS_VPT: begin
          volt_chan_start_point <= pwdata[6:0] > asrs_pkg::POINT_FULL ? asrs_pkg::POINT_FULL : pwdata[6:0];
          volt_chan_end_point <= pwdata[14:8] > asrs_pkg::POINT_FULL ? asrs_pkg::POINT_FULL : pwdata[14:8];
        end
        asrs_pkg::OFS_CPT: begin
          curr_chan_start_point <= pwdata[6:0] > asrs_pkg::POINT_FULL ? asrs_pkg::POINT_FULL : pwdata[6:0];
          curr_chan_end_point <= pwdata[14:8] > asrs_pkg::POINT_FULL ? asrs_pkg::POINT_FULL : pwdata[14:8];
        end
        default: ;
      endcase
    end
  end

  // Select terminal synchroniser; stage one feeds stage two only
  logic sel_meta;
  logic sel_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
    end else begin
      sel_meta <= channel_select_terminal;
      sel_sync <= sel_meta;
    end
  end

  // Channel mappers
  logic [15:0] volt_freq;
  logic [15:0] curr_freq;
  asrs_chan_map u_volt_map (
    .sample(volt_sample),
    .start_freq(volt_chan_start_freq),
    .end_freq(volt_chan_end_freq),
    .start_point(volt_chan_start_point),
    .end_point(volt_chan_end_point),
    .start_zero(volt_chan_start_enable),
    .freq(volt_freq)
  );
  asrs_chan_map u_curr_map (
    .sample(curr_sample),
    .start_freq(curr_chan_start_freq),
    .end_freq(curr_chan_end_freq),
    .start_point(curr_chan_start_point),
    .end_point(curr_chan_end_point),
    .start_zero(curr_chan_start_enable),
    .freq(curr_freq)
  );

  // Active limit set
  logic [15:0] max_act;
  logic [15:0] base_act;
  logic [15:0] pot_freq;
  logic [27:0] pot_prod;
  logic [16:0] sum_freq;
  logic [15:0] raw_ref;

  // second motor set selects the limits
  assign max_act = motor2_sel ? max_freq_setting_motor2 : max_freq_setting;
  assign base_act = motor2_sel ? base_freq_setting_motor2 : base_freq_setting;
  // Pot spans zero to the active maximum
  assign pot_prod = 28'(operator_pot_channel) * 28'(max_act);
  assign pot_freq = 16'(pot_prod / 28'(asrs_pkg::SAMPLE_FULL));
  assign sum_freq = 17'(volt_freq) + 17'(curr_freq);

  // Source selection, then clamp to the active maximum
  always_comb begin
    raw_ref = volt_freq;
    if (!select_assigned) begin
      raw_ref = sum_freq > 17'(max_act) ? max_act : sum_freq[15:0];
    end else begin
      case (input_pair_select_code)
        asrs_pkg::PAIR_POT_VOLT: raw_ref = sel_sync ? pot_freq : volt_freq;
        asrs_pkg::PAIR_POT_CURR: raw_ref = sel_sync ? pot_freq : curr_freq;
        default: raw_ref = sel_sync ? curr_freq : volt_freq;
      endcase
    end
    raw_ref = raw_ref > max_act ? max_act : raw_ref;
  end

  // Averaging ring; changing the filter code restarts it
  logic [15:0] ring [AVG_DEPTH];
  logic [PW-1:0] wptr;
  logic [4:0] fill;
  logic [20:0] acc;
  logic [4:0] filt_q;
  logic [4:0] win;
  logic [PW-1:0] old_idx;
  logic [15:0] avg;
  logic deadband_mode;

  assign deadband_mode = reference_filter_setting == asrs_pkg::FILT_DEADBAND;
  assign win = deadband_mode ? asrs_pkg::DEADBAND_AVG :
               (reference_filter_setting > asrs_pkg::FILT_MAX_AVG ? asrs_pkg::FILT_MAX_AVG : reference_filter_setting);
  assign old_idx = wptr - PW'(win);

  always_ff @(posedge pclk) begin
    if (sample_tick) begin
      ring[wptr] <= raw_ref;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr <= '0;
      fill <= 5'h00;
      acc <= 21'h000000;
      filt_q <= asrs_pkg::FILT_RST;
    end else if (filt_q != reference_filter_setting) begin
      filt_q <= reference_filter_setting;
      fill <= 5'h00;
      acc <= 21'h000000;
    end else if (sample_tick) begin
      wptr <= wptr + 1'b1;
      if (fill == win) begin
        acc <= acc + 21'(raw_ref) - 21'(ring[old_idx]);
      end else begin
        acc <= acc + 21'(raw_ref);
        fill <= fill + 5'h01;
      end
    end
  end

  assign avg = fill == 5'h00 ? 16'h0000 : 16'(acc / 21'(fill));

  // Deadband settle counter and comparison point
  logic [8:0] settle;
  logic [15:0] point;
  logic [15:0] diff;
  logic filt_phase;
  logic out_step;
  assign diff = avg > point ? avg - point : point - avg;
  assign filt_phase = settle != 9'(asrs_pkg::SETTLE_TICKS);

  // 500 ms of plain filtering first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle <= 9'h000;
    end else if (!deadband_mode || filt_q != reference_filter_setting) begin
      settle <= 9'h000;
    end else if (sample_tick && filt_phase) begin
      settle <= settle + 9'h001;
    end
  end

  // Output step one cycle after the tick, once the sum has moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_step <= 1'b0;
    end else begin
      out_step <= sample_tick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_ref <= 16'h0000;
      freq_ref_strobe <= 1'b0;
      point <= 16'h0000;
    end else begin
      freq_ref_strobe <= 1'b0;
      if (out_step) begin
        if (!deadband_mode || filt_phase) begin
          freq_ref <= avg;
          point <= avg;
          freq_ref_strobe <= 1'b1;
        end else if (diff >= asrs_pkg::DEADBAND_WIDTH) begin
          freq_ref <= avg;
          point <= avg;
          freq_ref_strobe <= 1'b1;
        end
      end
    end
  end

  // Active limits to the frequency generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_freq_active <= asrs_pkg::FREQ_BASE_RST;
      max_freq_active <= asrs_pkg::FREQ_MAX_RST;
    end else begin
      base_freq_active <= base_act;
      max_freq_active <= max_act;
    end
  end

  // Read multiplexer
  logic [31:0] rd_mux;
  logic addr_ok;
  always_comb begin
    rd_mux = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      asrs_pkg::OFS_BASE1: rd_mux = {16'h0000, base_freq_setting};
      asrs_pkg::OFS_MAX1: rd_mux = {16'h0000, max_freq_setting};
      asrs_pkg::OFS_BASE2: rd_mux = {16'h0000, base_freq_setting_motor2};
      asrs_pkg::OFS_MAX2: rd_mux = {16'h0000, max_freq_setting_motor2};
      asrs_pkg::OFS_CFG: rd_mux = {21'h000000, cfg};
      asrs_pkg::OFS_VSF: rd_mux = {16'h0000, volt_chan_start_freq};
      asrs_pkg::OFS_VEF: rd_mux = {16'h0000, volt_chan_end_freq};
      asrs_pkg::OFS_VPT: rd_mux = {17'h00000, volt_chan_end_point, 1'b0, volt_chan_start_point};
      asrs_pkg::OFS_CSF: rd_mux = {16'h0000, curr_chan_start_freq};
      asrs_pkg::OFS_CEF: rd_mux = {16'h0000, curr_chan_end_freq};
      asrs_pkg::OFS_CPT: rd_mux = {17'h00000, curr_chan_end_point, 1'b0, curr_chan_start_point};
      asrs_pkg::OFS_REF: rd_mux = {16'h0000, freq_ref};
      asrs_pkg::OFS_RAW: rd_mux = {16'h0000, raw_ref};
      asrs_pkg::OFS_STAT: rd_mux = {22'h000000, !filt_phase, sel_sync, fill, 3'h0};
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answer: registered ready in the first cycle of the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~pready;
      pslverr <= psel & ~pready & ~addr_ok;
      if (psel & ~pready & ~pwrite) begin
        prdata <= addr_ok ? rd_mux : 32'h00000000;
      end
    end
  end
endmodule
`default_nettype wire
